// >>> design/sxc_pkg.sv
package sxc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_EXT_CTRL   = 12'h0018;
  localparam logic [11:0] ADDR_DEV_STATUS = 12'h0008;
  localparam logic [11:0] ADDR_DEV_CTRL   = 12'h0000;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0020;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h0024;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_MASTER_ACTIVE = 19;
  localparam int BIT_DEV_RST_FLAG  = 20;
  localparam int BIT_RST_DONE      = 21;
  localparam int BIT_GATING_SUPP   = 31;
  localparam int BIT_SERIAL_EN     = 1;
  localparam int BIT_PIN2_IRQ_EN   = 2;
  localparam int BIT_PIN3_IRQ_EN   = 3;
  localparam int BIT_PIN2_VALUE    = 6;
  localparam int BIT_PIN3_VALUE    = 7;
  localparam int BIT_PIN2_DIR      = 10;
  localparam int BIT_PIN3_DIR      = 11;
  // Device control (own register)
  localparam int BIT_SW_RESET      = 0;
  localparam int BIT_DEV_RESET     = 1;
  localparam int BIT_MASTER_DIS    = 2;
  // Interrupt cause bits
  localparam int IRQ_PIN2          = 0;
  localparam int IRQ_PIN3          = 1;
  localparam int IRQ_RST_DONE      = 2;
  localparam int IRQ_WIDTH         = 3;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [1:0]  NVM_SIGNATURE_OK = 2'h1;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam int          RESET_DONE_NS    = 100;
  localparam int          CLK_NS           = 5;
  localparam int          RESET_DONE_CYC   = (RESET_DONE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  RESET_DONE_CNT   = 8'(RESET_DONE_CYC);

  // Configurable initial values from on-chip non-volatile memory
  typedef struct packed {
    logic [1:0] signature;
    logic       gatingSupported;
    logic       serialEnable;
    logic       pin2Value;
    logic       pin3Value;
    logic       pin2Dir;
    logic       pin3Dir;
  } sxc_nvm_word_t;

  typedef struct packed {
    logic serialEnable;
    logic pin2IrqEn;
    logic pin3IrqEn;
    logic pin2Value;
    logic pin3Value;
    logic pin2Dir;
    logic pin3Dir;
  } sxc_ext_ctrl_t;

endpackage : sxc_pkg

// >>> design/sxc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_sync2 (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Data
  input  wire logic [1:0] asyncIn,
  output var  logic [1:0] syncOut
);
  logic [1:0] stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= 2'h0;
      syncOut    <= 2'h0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule : sxc_sync2
`default_nettype wire

// >>> design/sxc_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_edge_det (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Levels in, one-cycle change pulses out
  input  wire logic [1:0] level,
  output var  logic [1:0] changed
);
  logic [1:0] last_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      last_reg <= 2'h0;
    end else begin
      last_reg <= level;
    end
  end

  // Any edge counts as an interrupt event
  always_comb begin
    changed = level ^ last_reg;
  end
endmodule : sxc_edge_det
`default_nettype wire

// >>> design/sxc_status_ext_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_status_ext_ctrl (
  // Clock and resets
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                powerOnReset,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Non-volatile configuration word
  input  wire sxc_pkg::sxc_nvm_word_t nvmWord,
  // Bus master activity
  input  wire logic                masterPending,
  input  wire logic                masterReqIn,
  output var  logic                masterReqOut,
  // Software pins (input, output, enable)
  input  wire logic                pin2In,
  input  wire logic                pin3In,
  output var  logic                pin2Out,
  output var  logic                pin2Oe,
  output var  logic                pin3Out,
  output var  logic                pin3Oe,
  // Serial engine hand-over
  output var  logic                serialSelect,
  // Resets requested by software
  output var  logic                deviceResetPulse,
  // Interrupt
  output var  logic                irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic wrEn, rdEn, addrOk;
  always_comb begin
    addrOk = (paddr == sxc_pkg::ADDR_EXT_CTRL) || (paddr == sxc_pkg::ADDR_DEV_STATUS)
          || (paddr == sxc_pkg::ADDR_DEV_CTRL) || (paddr == sxc_pkg::ADDR_IRQ_STATUS)
          || (paddr == sxc_pkg::ADDR_IRQ_MASK);
    wrEn   = psel && penable && pready && pwrite && addrOk;
    rdEn   = psel && !penable && !pwrite;
  end
  // No wait state: ready rises in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
    end
  end

  // ---------------------------------------------------------------
  // Reset sequencing
  // ---------------------------------------------------------------
  logic        swResetReq, devResetReq, masterDisable_reg;
  logic        resetActive_reg;
  logic [7:0]  resetCnt_reg;
  logic        resetDone;
  logic        nvmValid;
  always_comb begin
    swResetReq  = wrEn && (paddr == sxc_pkg::ADDR_DEV_CTRL) && pwdata[sxc_pkg::BIT_SW_RESET];
    devResetReq = wrEn && (paddr == sxc_pkg::ADDR_DEV_CTRL) && pwdata[sxc_pkg::BIT_DEV_RESET];
    nvmValid    = nvmWord.signature == sxc_pkg::NVM_SIGNATURE_OK;
    resetDone   = resetActive_reg && (resetCnt_reg == 8'h01);
  end
  // Internal reset takes a fixed time, then reports completion
  always_ff @(posedge clk) begin
    if (reset) begin
      resetActive_reg <= 1'b0;
      resetCnt_reg    <= 8'h00;
    end else if (swResetReq || devResetReq) begin
      resetActive_reg <= 1'b1;
      resetCnt_reg    <= sxc_pkg::RESET_DONE_CNT;
    end else if (resetActive_reg) begin
      resetCnt_reg    <= resetCnt_reg - 8'h01;
      resetActive_reg <= !resetDone;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      deviceResetPulse <= 1'b0;
    end else begin
      deviceResetPulse <= devResetReq;
    end
  end

  // ---------------------------------------------------------------
  // Device control
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      masterDisable_reg <= 1'b0;
    end else if (wrEn && paddr == sxc_pkg::ADDR_DEV_CTRL) begin
      masterDisable_reg <= pwdata[sxc_pkg::BIT_MASTER_DIS];
    end
  end
  // Gate requests; disable wins regardless of status
  always_ff @(posedge clk) begin
    if (reset) begin
      masterReqOut <= 1'b0;
    end else begin
      masterReqOut <= masterReqIn && !masterDisable_reg;
    end
  end

  // ---------------------------------------------------------------
  // Status bits
  // ---------------------------------------------------------------
  logic masterActive_reg, devRstFlag_reg, rstDoneFlag_reg, gatingSupp_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      masterActive_reg <= 1'b1;
    end else begin
      masterActive_reg <= !(masterDisable_reg && masterPending);
    end
  end
  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      devRstFlag_reg <= 1'b0;
    end else if (devResetReq) begin
      devRstFlag_reg <= 1'b1;
    end else if (wrEn && paddr == sxc_pkg::ADDR_DEV_STATUS
                 && pwdata[sxc_pkg::BIT_DEV_RST_FLAG]) begin
      devRstFlag_reg <= 1'b0;
    end
  end
  // Low while an internal reset runs, set again when it completes
  always_ff @(posedge clk) begin
    if (reset) begin
      rstDoneFlag_reg <= 1'b1;
    end else if (resetDone) begin
      rstDoneFlag_reg <= 1'b1;
    end else if (swResetReq || devResetReq) begin
      rstDoneFlag_reg <= 1'b0;
    end
  end
  // Memory word is sampled on the clock, never under reset value path
  logic nvmLoaded_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      nvmLoaded_reg  <= 1'b0;
      gatingSupp_reg <= 1'b0;
    end else if (!nvmLoaded_reg) begin
      nvmLoaded_reg  <= 1'b1;
      gatingSupp_reg <= nvmValid && nvmWord.gatingSupported;
    end
  end

  // ---------------------------------------------------------------
  // Extended control
  // ---------------------------------------------------------------
  sxc_pkg::sxc_ext_ctrl_t ext_reg;
  logic                   dirLoaded_reg;
  logic                   extWr;
  always_comb begin
    extWr = wrEn && (paddr == sxc_pkg::ADDR_EXT_CTRL);
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_reg.serialEnable <= 1'b0;
      ext_reg.pin2IrqEn    <= 1'b0;
      ext_reg.pin3IrqEn    <= 1'b0;
      ext_reg.pin2Value    <= 1'b0;
      ext_reg.pin3Value    <= 1'b0;
    end else if (!nvmLoaded_reg) begin
      ext_reg.serialEnable <= nvmValid && nvmWord.serialEnable;
      ext_reg.pin2Value    <= nvmValid && nvmWord.pin2Value;
      ext_reg.pin3Value    <= nvmValid && nvmWord.pin3Value;
    end else if (extWr) begin
      ext_reg.serialEnable <= pwdata[sxc_pkg::BIT_SERIAL_EN];
      ext_reg.pin2IrqEn    <= pwdata[sxc_pkg::BIT_PIN2_IRQ_EN];
      ext_reg.pin3IrqEn    <= pwdata[sxc_pkg::BIT_PIN3_IRQ_EN];
      ext_reg.pin2Value    <= pwdata[sxc_pkg::BIT_PIN2_VALUE];
      ext_reg.pin3Value    <= pwdata[sxc_pkg::BIT_PIN3_VALUE];
    end
    // Directions see only power-on reset; one process keeps ext_reg single-driven
    if (powerOnReset) begin
      ext_reg.pin2Dir <= 1'b0;
      ext_reg.pin3Dir <= 1'b0;
      dirLoaded_reg   <= 1'b0;
    end else if (!dirLoaded_reg) begin
      dirLoaded_reg   <= 1'b1;
      ext_reg.pin2Dir <= nvmValid && nvmWord.pin2Dir;
      ext_reg.pin3Dir <= nvmValid && nvmWord.pin3Dir;
    end else if (extWr) begin
      ext_reg.pin2Dir <= pwdata[sxc_pkg::BIT_PIN2_DIR];
      ext_reg.pin3Dir <= pwdata[sxc_pkg::BIT_PIN3_DIR];
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  logic [1:0] pinSync, pinEdge;
  sxc_sync2 u_sync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({pin3In, pin2In}),
    .syncOut (pinSync)
  );
  sxc_edge_det u_edge (
    .clk     (clk),
    .reset   (reset),
    .level   (pinSync),
    .changed (pinEdge)
  );
  // Serial engine owns pin 2 when enabled, so general drive is released
  always_ff @(posedge clk) begin
    if (reset) begin
      pin2Out      <= 1'b0;
      pin2Oe       <= 1'b0;
      pin3Out      <= 1'b0;
      pin3Oe       <= 1'b0;
      serialSelect <= 1'b0;
    end else begin
      serialSelect <= ext_reg.serialEnable;
      pin2Out      <= ext_reg.pin2Value;
      pin2Oe       <= ext_reg.pin2Dir && !ext_reg.serialEnable;
      pin3Out      <= ext_reg.pin3Value;
      pin3Oe       <= ext_reg.pin3Dir;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [sxc_pkg::IRQ_WIDTH-1:0] irqStat_reg, irqMask_reg, irqEvent;
  always_comb begin
    irqEvent = '0;
    irqEvent[sxc_pkg::IRQ_PIN2] = pinEdge[0] && ext_reg.pin2IrqEn
                                  && !ext_reg.pin2Dir && !ext_reg.serialEnable;
    irqEvent[sxc_pkg::IRQ_PIN3] = pinEdge[1] && ext_reg.pin3IrqEn && !ext_reg.pin3Dir;
    irqEvent[sxc_pkg::IRQ_RST_DONE] = resetDone;
  end
  generate
    for (genvar i = 0; i < sxc_pkg::IRQ_WIDTH; i++) begin : g_irq
      always_ff @(posedge clk) begin
        if (reset) begin
          irqStat_reg[i] <= 1'b0;
          irqMask_reg[i] <= 1'b0;
        end else begin
          if (irqEvent[i]) begin
            irqStat_reg[i] <= 1'b1;
          end else if (wrEn && paddr == sxc_pkg::ADDR_IRQ_STATUS && pwdata[i]) begin
            irqStat_reg[i] <= 1'b0;
          end
          if (wrEn && paddr == sxc_pkg::ADDR_IRQ_MASK) begin
            irqMask_reg[i] <= pwdata[i];
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] rdWord;
  always_comb begin
    rdWord = sxc_pkg::ZERO_WORD;
    case (paddr)
      sxc_pkg::ADDR_DEV_STATUS: begin
        rdWord[sxc_pkg::BIT_MASTER_ACTIVE] = masterActive_reg;
        rdWord[sxc_pkg::BIT_DEV_RST_FLAG]  = devRstFlag_reg;
        rdWord[sxc_pkg::BIT_RST_DONE]      = rstDoneFlag_reg;
        rdWord[sxc_pkg::BIT_GATING_SUPP]   = gatingSupp_reg;
      end
      sxc_pkg::ADDR_EXT_CTRL: begin
        rdWord[sxc_pkg::BIT_SERIAL_EN]   = ext_reg.serialEnable;
        rdWord[sxc_pkg::BIT_PIN2_IRQ_EN] = ext_reg.pin2IrqEn;
        rdWord[sxc_pkg::BIT_PIN3_IRQ_EN] = ext_reg.pin3IrqEn;
        rdWord[sxc_pkg::BIT_PIN2_VALUE]  = ext_reg.pin2Dir ? ext_reg.pin2Value : pinSync[0];
        rdWord[sxc_pkg::BIT_PIN3_VALUE]  = ext_reg.pin3Dir ? ext_reg.pin3Value : pinSync[1];
        rdWord[sxc_pkg::BIT_PIN2_DIR]    = ext_reg.pin2Dir;
        rdWord[sxc_pkg::BIT_PIN3_DIR]    = ext_reg.pin3Dir;
      end
      sxc_pkg::ADDR_DEV_CTRL: begin
        rdWord[sxc_pkg::BIT_MASTER_DIS] = masterDisable_reg;
      end
      sxc_pkg::ADDR_IRQ_STATUS: rdWord[sxc_pkg::IRQ_WIDTH-1:0] = irqStat_reg;
      sxc_pkg::ADDR_IRQ_MASK:   rdWord[sxc_pkg::IRQ_WIDTH-1:0] = irqMask_reg;
      default: rdWord = sxc_pkg::ZERO_WORD;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= sxc_pkg::ZERO_WORD;
    end else if (rdEn) begin
      prdata <= rdWord;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  master_status_a: assert property (@(posedge clk) disable iff (reset)
    masterDisable_reg && masterPending |=> !masterActive_reg)
    else $error("master active not cleared");
  master_gate_a: assert property (@(posedge clk) disable iff (reset)
    masterDisable_reg |=> !masterReqOut)
    else $error("master request while disabled");
  rst_flag_set_a: assert property (@(posedge clk) disable iff (reset)
    devResetReq |=> devRstFlag_reg)
    else $error("device reset flag not set");
  rst_flag_keep_a: assert property (@(posedge clk) disable iff (reset)
    wrEn && paddr == sxc_pkg::ADDR_DEV_STATUS && !pwdata[sxc_pkg::BIT_DEV_RST_FLAG]
    && devRstFlag_reg |=> devRstFlag_reg)
    else $error("reset flag cleared by zero");
  rst_done_a: assert property (@(posedge clk) disable iff (reset)
    swResetReq |=> !rstDoneFlag_reg ##[1:40] rstDoneFlag_reg)
    else $error("reset done not reported");
  status_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    $rose(pready) && !pwrite && paddr == sxc_pkg::ADDR_DEV_STATUS
    |-> prdata[18:11] == 8'h00 && prdata[30:22] == 9'h000)
    else $error("reserved status bits nonzero");
  pin2_drive_a: assert property (@(posedge clk) disable iff (reset)
    ext_reg.pin2Dir && !ext_reg.serialEnable |=> pin2Oe && pin2Out == $past(ext_reg.pin2Value))
    else $error("pin 2 not driven");
  pin3_irq_a: assert property (@(posedge clk) disable iff (reset)
    ext_reg.pin3Dir && !irqStat_reg[sxc_pkg::IRQ_PIN3] |=> !irqStat_reg[sxc_pkg::IRQ_PIN3])
    else $error("pin 3 interrupt while output");
  dir_keep_a: assert property (@(posedge clk) disable iff (powerOnReset)
    dirLoaded_reg && reset |=> ext_reg.pin2Dir == $past(ext_reg.pin2Dir))
    else $error("direction lost on reset");
  serial_sel_a: assert property (@(posedge clk) disable iff (reset)
    ext_reg.serialEnable |=> serialSelect && !pin2Oe)
    else $error("serial hand-over missing");
  cov_dev_reset_c: cover property (@(posedge clk) devResetReq ##[1:40] resetDone);
  cov_pin_irq_c:   cover property (@(posedge clk) irqEvent[sxc_pkg::IRQ_PIN2] ##2 irq);
  cov_master_c:    cover property (@(posedge clk) masterDisable_reg && masterPending);
endmodule : sxc_status_ext_ctrl
`default_nettype wire

// >>> tb/sxc_apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_apb_host (
  // Clock
  input  wire logic        clk,
  // APB master side
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // Answer taken at the very edge that samples pready, then released
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : sxc_apb_host
`default_nettype wire

// >>> tb/test_status_ext_control_pins.sv
`timescale 1ns/1ps
`default_nettype none
module test_status_ext_control_pins;
  logic clk = 1'b0, reset = 1'b1, powerOnReset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  sxc_pkg::sxc_nvm_word_t nvmWord = '{2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic masterPending = 1'b0, masterReqIn = 1'b0, masterReqOut;
  logic pin2Out, pin2Oe, pin3Out, pin3Oe, serialSelect, deviceResetPulse, irq;
  logic [1:0] pinExt = 2'b10;
  logic seenDevRst = 1'b0;
  int errCount = 0, nTests = 0;
  // Pin levels: the device wins while it drives, else the outside source
  wire logic pin2Lvl = pin2Oe ? pin2Out : pinExt[0];
  wire logic pin3Lvl = pin3Oe ? pin3Out : pinExt[1];

  always #2.5 clk = ~clk;
  always @(posedge clk) if (deviceResetPulse === 1'b1) seenDevRst <= 1'b1;

  sxc_status_ext_ctrl u_sxc_status_ext_ctrl (.clk(clk), .reset(reset),
    .powerOnReset(powerOnReset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvmWord(nvmWord), .masterPending(masterPending), .masterReqIn(masterReqIn),
    .masterReqOut(masterReqOut), .pin2In(pin2Lvl), .pin3In(pin3Lvl), .pin2Out(pin2Out),
    .pin2Oe(pin2Oe), .pin3Out(pin3Out), .pin3Oe(pin3Oe), .serialSelect(serialSelect),
    .deviceResetPulse(deviceResetPulse), .irq(irq));

  sxc_apb_host u_sxc_apb_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      errCount++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_sxc_apb_host.xfer(1'b1, a, d, q, err);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    u_sxc_apb_host.xfer(1'b0, a, 32'h0000_0000, q, err);
  endtask : rd

  task automatic giveVerdict;
    $display("Comparisons %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : giveVerdict

  // Both resets are synchronous; the bus waits two edges after release
  task automatic doReset(input logic por);
    @(posedge clk);
    reset        <= 1'b1;
    powerOnReset <= por;
    repeat (8) @(posedge clk);
    reset        <= 1'b0;
    powerOnReset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : doReset

  // Edge on an input pin: flagged, masked, cleared, and ignored when disabled
  // Static, so the pin index may steer a non-blocking assignment
  task pinIrq(input int i);
    logic [31:0] b;
    b = 32'h0000_0001 << i;
    wr(sxc_pkg::ADDR_EXT_CTRL, 32'h0000_0004 << i);
    wr(sxc_pkg::ADDR_IRQ_MASK, b);
    pinExt[i] <= ~pinExt[i];
    repeat (8) @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    rd(sxc_pkg::ADDR_IRQ_STATUS);
    chk(q & b, b);
    rd(sxc_pkg::ADDR_EXT_CTRL);
    chk(q & (32'h0000_0040 << i), 32'(pinExt[i]) << (6 + i));
    wr(sxc_pkg::ADDR_IRQ_STATUS, b);
    wr(sxc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    pinExt[i] <= ~pinExt[i];
    repeat (8) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    wr(sxc_pkg::ADDR_IRQ_STATUS, b);
    wr(sxc_pkg::ADDR_EXT_CTRL, 32'h0000_0000);
    pinExt[i] <= ~pinExt[i];
    repeat (8) @(posedge clk);
    rd(sxc_pkg::ADDR_IRQ_STATUS);
    chk(q & b, 32'h0000_0000);
  endtask : pinIrq

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #100000;
    errCount++;
    giveVerdict();
  end

  initial begin
    doReset(1'b1);
    rd(sxc_pkg::ADDR_DEV_STATUS);
    chk(q & 32'hFFFF_F800, 32'h8028_0000);
    chk(32'(err), 32'h0000_0000);
    rd(sxc_pkg::ADDR_EXT_CTRL);
    chk(q & 32'h0000_0CCE, 32'h0000_04C0);
    chk(32'({pin2Oe, pin2Out, pin3Oe}), 32'h0000_0006);
    rd(12'h100);
    chk(32'(err), 32'h0000_0001);
    chk(q, 32'h0000_0000);
    wr(sxc_pkg::ADDR_EXT_CTRL, 32'h0000_0880);
    // Pin outputs are registered behind the control register
    repeat (2) @(posedge clk);
    chk(32'({pin3Oe, pin3Out, pin2Oe}), 32'h0000_0006);
    doReset(1'b0);
    rd(sxc_pkg::ADDR_EXT_CTRL);
    chk(q & 32'h0000_0C00, 32'h0000_0800);
    wr(sxc_pkg::ADDR_EXT_CTRL, 32'h0000_0402);
    repeat (2) @(posedge clk);
    chk(32'({serialSelect, pin2Oe}), 32'h0000_0002);
    pinIrq(0);
    pinIrq(1);
    masterPending <= 1'b1;
    masterReqIn   <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(masterReqOut), 32'h0000_0001);
    wr(sxc_pkg::ADDR_DEV_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk(32'(masterReqOut), 32'h0000_0000);
    rd(sxc_pkg::ADDR_DEV_STATUS);
    chk(q & 32'h0008_0000, 32'h0000_0000);
    masterPending <= 1'b0;
    repeat (2) @(posedge clk);
    rd(sxc_pkg::ADDR_DEV_STATUS);
    chk(q & 32'h0008_0000, 32'h0008_0000);
    chk(32'(masterReqOut), 32'h0000_0000);
    wr(sxc_pkg::ADDR_DEV_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(32'(masterReqOut), 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      wr(sxc_pkg::ADDR_DEV_CTRL, 32'h0000_0001 << k);
      rd(sxc_pkg::ADDR_DEV_STATUS);
      chk(q & 32'h0030_0000, 32'(k) << 20);
      repeat (30) @(posedge clk);
      rd(sxc_pkg::ADDR_DEV_STATUS);
      chk(q & 32'h0030_0000, 32'h0020_0000 | (32'(k) << 20));
    end
    chk(32'(seenDevRst), 32'h0000_0001);
    rd(sxc_pkg::ADDR_IRQ_STATUS);
    chk(q & 32'h0000_0004, 32'h0000_0004);
    wr(sxc_pkg::ADDR_DEV_STATUS, 32'h0000_0000);
    rd(sxc_pkg::ADDR_DEV_STATUS);
    chk(q & 32'h0010_0000, 32'h0010_0000);
    wr(sxc_pkg::ADDR_DEV_STATUS, 32'h0010_0000);
    rd(sxc_pkg::ADDR_DEV_STATUS);
    chk(q & 32'h0010_0000, 32'h0000_0000);
    nvmWord <= '{2'h2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    pinExt  <= 2'b00;
    doReset(1'b1);
    rd(sxc_pkg::ADDR_DEV_STATUS);
    chk(q & 32'hFFFF_F800, 32'h0028_0000);
    rd(sxc_pkg::ADDR_EXT_CTRL);
    chk(q & 32'h0000_0CCE, 32'h0000_0000);
    giveVerdict();
  end
endmodule : test_status_ext_control_pins
`default_nettype wire
